// file: src/rsecc_pkg.sv
// Constants shared by the Reed-Solomon command-trigger block
// Assumes a 32-bit classic Wishbone register bus with byte addresses
package rsecc_pkg;
   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADR_CMD   = 8'h68;
   localparam logic [7:0] ADR_WPAR1 = 8'h78;
   localparam logic [7:0] ADR_WPAR2 = 8'h7C;
   localparam logic [7:0] ADR_WPAR3 = 8'h80;
   localparam logic [7:0] ADR_STAT  = 8'h84;
   localparam logic [7:0] ADR_IRQST = 8'h88;
   localparam logic [7:0] ADR_IRQMK = 8'h8C;
   // -------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------
   localparam int          BIT_ENABLE    = 0;
   localparam int          BIT_RELOAD    = 1;
   localparam int          BIT_PRECOMP   = 2;
   localparam int          IRQ_READDONE  = 0;
   localparam int          IRQ_PRECOMP   = 1;
   localparam int          IRQ_RELOAD    = 2;
   localparam int          IRQ_BITS      = 3;
   localparam logic [71:0] PARITY_RESET  = 72'h0;
   localparam logic [1:0]  OUTCOME_CLEAN = 2'h0;
   localparam logic [1:0]  OUTCOME_FIX   = 2'h1;
   localparam int          BLOCK_BYTES   = 512;
   localparam int          PARITY_BYTES  = 9;
   typedef enum logic [1:0] {RS_IDLE, RS_PRECOMP, RS_RELOAD} rsecc_state_t;
endpackage

// file: src/rsecc_command_triggers.sv
// What this block does
// - Bit 2 starts parity pre-compute, self-clears
// - Pre-compute drains 512 transmit bytes through encoder
// - Pre-compute bytes never reach the flash
// - Nine parity bytes readable after pre-compute
// - Bit 1 reload only after correctable errors
// - Reload fills input FIFO with corrected block
// - Enable bit gates outcome capture and both pass starts, not the readDone interrupt
// - Two-bit outcome: 00 clean, 01 fixable, 1x bad
//
// Command-trigger part of the Reed-Solomon engine, with Wishbone slave
// Assumes byte streams with valid/ready and a one-cycle readDone pulse
`timescale 1ns/10ps
module rsecc_command_triggers
   import rsecc_pkg::*;
#(
   parameter int BLOCK = BLOCK_BYTES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatI,
   output logic      [31:0] wbDatO,
   output logic             wbAck,
   input  wire logic [7:0]  txData,
   input  wire logic        txValid,
   output logic             txReady,
   output logic             flashHold,
   input  wire logic [7:0]  corrData,
   input  wire logic        corrValid,
   output logic             corrReady,
   output logic [7:0]       inData,
   output logic             inValid,
   input  wire logic        inReady,
   input  wire logic        readDone,
   input  wire logic [1:0]  outcomeIn,
   output logic             codeCheckEnable,
   output logic             irq
);
   // Refuse block sizes that the 10-bit byte counter cannot serve
   if (BLOCK < 2 || BLOCK > 1024) begin : g_bad_block
      $error("BLOCK must lie in 2..1024");
   end

   localparam logic [9:0] LAST = 10'(BLOCK - 1);

   rsecc_state_t         state;
   logic [9:0]           count;
   logic [71:0]          writeParity;
   logic [1:0]           readOutcome;
   logic [IRQ_BITS-1:0]  intStatus;
   logic [IRQ_BITS-1:0]  intMask;

   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   wire        req       = wbCyc & wbStb & ~wbAck;
   wire        wr        = req & wbWe & ce;
   wire        wrCmd     = wr && wbAdr == ADR_CMD && wbSel[0];
   wire        wrIrqSt   = wr && wbAdr == ADR_IRQST && wbSel[0];
   wire        wrIrqMk   = wr && wbAdr == ADR_IRQMK && wbSel[0];
   wire        busyPre   = state == RS_PRECOMP;
   wire        busyRel   = state == RS_RELOAD;
   // Trigger bits read as busy flags
   wire [31:0] cmdRead   = {29'h0, busyPre, busyRel, codeCheckEnable};
   wire        goPre     = wrCmd && wbDatI[BIT_PRECOMP] && codeCheckEnable && state == RS_IDLE;
   wire        goRel     = wrCmd && wbDatI[BIT_RELOAD] && codeCheckEnable && state == RS_IDLE
                           && readOutcome == OUTCOME_FIX;
   wire [31:0] readMux   = (wbAdr == ADR_CMD)   ? cmdRead :
                           (wbAdr == ADR_WPAR1) ? writeParity[31:0] :
                           (wbAdr == ADR_WPAR2) ? writeParity[63:32] :
                           (wbAdr == ADR_WPAR3) ? {24'h0, writeParity[71:64]} :
                           (wbAdr == ADR_STAT)  ? {30'h0, readOutcome} :
                           (wbAdr == ADR_IRQST) ? {29'h0, intStatus} :
                           (wbAdr == ADR_IRQMK) ? {29'h0, intMask} : 32'h0;

   // -------------------------------------------------------------
   // Streams
   // -------------------------------------------------------------
   // Pre-compute pass: bytes go to the encoder only, flash path held off
   assign txReady   = busyPre;
   assign flashHold = busyPre;
   assign corrReady = busyRel && (!inValid || inReady);
   wire   txTake    = ce && txValid && txReady;
   wire   corrTake  = ce && corrValid && corrReady;
   wire   lastByte  = count == LAST;
   wire   preDone   = txTake && lastByte;
   wire   relDone   = corrTake && lastByte;

   // Byte-serial shift encoder; feedback folds incoming byte into the top
   wire [7:0]  feedback   = txData ^ writeParity[71:64];
   wire [71:0] nextParity = {writeParity[63:0], 8'h00} ^ {PARITY_BYTES{feedback}};

   wire [IRQ_BITS-1:0] events   = {relDone, preDone, ce & readDone};
   wire [IRQ_BITS-1:0] clearMsk = wrIrqSt ? wbDatI[IRQ_BITS-1:0] : '0;
   assign irq = |(intStatus & intMask);

   // -------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wbAck  <= 1'b0;
         wbDatO <= 32'h0;
      end else if (ce) begin
         wbAck  <= wbCyc & wbStb & ~wbAck;
         wbDatO <= readMux;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         codeCheckEnable <= 1'b0;
         intMask         <= '0;
      end else begin
         if (wrCmd) codeCheckEnable <= wbDatI[BIT_ENABLE];
         if (wrIrqMk) intMask <= wbDatI[IRQ_BITS-1:0];
      end
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) intStatus <= '0;
      else intStatus <= (intStatus & ~clearMsk) | events;
   end

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= RS_IDLE;
         count <= 10'h0;
      end else if (ce) begin
         case (state)
            RS_IDLE: begin
               count <= 10'h0;
               if (goPre) state <= RS_PRECOMP;
               else if (goRel) state <= RS_RELOAD;
            end
            RS_PRECOMP: begin
               if (txTake) count <= count + 10'h1;
               if (preDone) state <= RS_IDLE;
            end
            RS_RELOAD: begin
               if (corrTake) count <= count + 10'h1;
               if (relDone) state <= RS_IDLE;
            end
            default: state <= RS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) writeParity <= PARITY_RESET;
      else if (ce && goPre) writeParity <= PARITY_RESET;
      else if (txTake) writeParity <= nextParity;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) readOutcome <= OUTCOME_CLEAN;
      else if (ce && readDone && codeCheckEnable) readOutcome <= outcomeIn;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         inValid <= 1'b0;
         inData  <= 8'h00;
      end else if (corrTake) begin
         inValid <= 1'b1;
         inData  <= corrData;
      end else if (ce && inReady) begin
         inValid <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_pre_bit_clear;
      @(posedge clock) disable iff (!rst_n) preDone |=> !cmdRead[BIT_PRECOMP] && intStatus[IRQ_PRECOMP];
   endproperty
   a_pre_bit_clear: assert property (p_pre_bit_clear) else $error("precompute bit stuck");

   property p_pre_ends;
      @(posedge clock) disable iff (!rst_n) (busyPre && txTake && count == LAST) |=> state == RS_IDLE;
   endproperty
   a_pre_ends: assert property (p_pre_ends) else $error("precompute did not end on last byte");

   property p_no_flash;
      @(posedge clock) disable iff (!rst_n) (state == RS_PRECOMP) |-> flashHold && !corrReady;
   endproperty
   a_no_flash: assert property (p_no_flash) else $error("flash path open during precompute");

   property p_parity_kept;
      @(posedge clock) disable iff (!rst_n) (busyPre && preDone) |=> writeParity == $past(nextParity) ##1
         (state != RS_IDLE || writeParity == $past(writeParity));
   endproperty
   a_parity_kept: assert property (p_parity_kept) else $error("parity not captured");

   property p_reload_cause;
      @(posedge clock) disable iff (!rst_n) $rose(busyRel) |-> $past(readOutcome) == OUTCOME_FIX
         && $past(codeCheckEnable);
   endproperty
   a_reload_cause: assert property (p_reload_cause) else $error("reload without correctable errors");

   property p_reload_data;
      @(posedge clock) disable iff (!rst_n) corrTake |=> inValid && inData == $past(corrData);
   endproperty
   a_reload_data: assert property (p_reload_data) else $error("corrected byte not loaded");

   property p_disabled_idle;
      @(posedge clock) disable iff (!rst_n) (state == RS_IDLE && !codeCheckEnable) |=> state == RS_IDLE;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("pass started while disabled");

   property p_outcome;
      @(posedge clock) disable iff (!rst_n) (ce && readDone && codeCheckEnable) |=>
         readOutcome == $past(outcomeIn) && intStatus[IRQ_READDONE];
   endproperty
   a_outcome: assert property (p_outcome) else $error("read outcome not reported");

   property p_busy_read;
      @(posedge clock) disable iff (!rst_n) busyRel |-> cmdRead[BIT_RELOAD] && !cmdRead[BIT_PRECOMP];
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("reload bit not showing busy");
endmodule

// file: bench/rsecc_far_side.sv
// Far-side model: transmit FIFO source, corrected-byte source, input FIFO sink
// Assumes ce stays high; sources and sink stall every other cycle
`timescale 1ns/10ps
module rsecc_far_side (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       txReady,
   output logic      [7:0] txData,
   output logic            txValid,
   input  wire logic       corrReady,
   output logic      [7:0] corrData,
   output logic            corrValid,
   input  wire logic [7:0] inData,
   input  wire logic       inValid,
   output logic            inReady,
   output int              txCount,
   output int              inCount,
   output int              inBad
);
   logic phase;
   int   corrCount;
   assign txValid   = phase;
   assign corrValid = ~phase;
   assign inReady   = phase;
   // Idle data shows the inverse so stale bytes are never taken for good ones
   assign txData    = txValid ? txCount[7:0] : ~txCount[7:0];
   assign corrData  = corrValid ? corrCount[7:0] : ~corrCount[7:0];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase     <= 1'b0;
         txCount   <= 0;
         corrCount <= 0;
         inCount   <= 0;
         inBad     <= 0;
      end else begin
         phase <= ~phase;
         if (txValid && txReady) txCount <= txCount + 1;
         if (corrValid && corrReady) corrCount <= corrCount + 1;
         if (inValid && inReady) begin
            inCount <= inCount + 1;
            if (inData !== inCount[7:0]) inBad <= inBad + 1;
         end
      end
   end
endmodule

// file: bench/test_rsecc_command_triggers.sv
// Self-checking bench for the command-trigger block
// Assumes the far-side model feeds byte k of every stream as value k
`timescale 1ns/10ps
module test_rsecc_command_triggers;
   import rsecc_pkg::*;
   localparam int BLK = 8;
   logic clock = 0, rst_n = 0, ce = 1, wbCyc = 0, wbStb = 0, wbWe = 0, readDone = 0;
   logic [7:0] wbAdr = 0, txData, corrData, inData;
   logic [3:0] wbSel = 0;
   logic [31:0] wbDatI = 0, wbDatO, q;
   logic [1:0] outcomeIn = 0;
   logic wbAck, txReady, flashHold, corrReady, inValid, inReady, txValid, corrValid, codeCheckEnable, irq;
   logic [71:0] p;
   logic [1:0] outcomes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   int txCount, inCount, inBad, mismatches = 0, n_compared = 0, cycles = 0;
   always #5 clock = ~clock;
   rsecc_command_triggers #(.BLOCK(BLK)) uut (.clock(clock), .rst_n(rst_n), .ce(ce), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
      .wbAck(wbAck), .txData(txData), .txValid(txValid), .txReady(txReady), .flashHold(flashHold),
      .corrData(corrData), .corrValid(corrValid), .corrReady(corrReady), .inData(inData),
      .inValid(inValid), .inReady(inReady), .readDone(readDone), .outcomeIn(outcomeIn),
      .codeCheckEnable(codeCheckEnable), .irq(irq));
   rsecc_far_side far (.clock(clock), .rst_n(rst_n), .txReady(txReady), .txData(txData),
      .txValid(txValid), .corrReady(corrReady), .corrData(corrData), .corrValid(corrValid),
      .inData(inData), .inValid(inValid), .inReady(inReady), .txCount(txCount),
      .inCount(inCount), .inBad(inBad));
   // ----------------------------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w; wbAdr <= a; wbDatI <= d; wbSel <= 4'hF;
      do @(posedge clock); while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0; wbStb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic waitIrq(input int b);
      do bus(1'b0, ADR_IRQST, 32'h0); while (q[b] !== 1'b1);
   endtask
   task automatic pulse(input logic [1:0] o);
      @(posedge clock);
      readDone <= 1'b1; outcomeIn <= o;
      @(posedge clock);
      readDone <= 1'b0;
   endtask
   function automatic logic [71:0] parity(input int n);
      logic [71:0] r;
      logic [7:0]  fb;
      r = 72'h0;
      for (int i = 0; i < n; i++) begin
         fb = i[7:0] ^ r[71:64];
         r = {r[63:0], 8'h00} ^ {9{fb}};
      end
      return r;
   endfunction
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         conclude;
      end
   end
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADR_CMD, 32'h0);
      rd(ADR_WPAR1, 32'h0);
      rd(ADR_STAT, 32'h0);
      rd(8'h00, 32'h0);
      bus(1'b1, ADR_CMD, 32'h4);
      rd(ADR_CMD, 32'h0);
      chk(txCount, 0);
      bus(1'b1, ADR_CMD, 32'h1);
      chk(codeCheckEnable, 1);
      bus(1'b1, ADR_CMD, 32'h5);
      rd(ADR_CMD, 32'h5);
      chk(flashHold, 1);
      waitIrq(IRQ_PRECOMP);
      rd(ADR_CMD, 32'h1);
      chk(txCount, BLK);
      chk(flashHold, 0);
      p = parity(BLK);
      rd(ADR_WPAR1, p[31:0]);
      rd(ADR_WPAR2, p[63:32]);
      rd(ADR_WPAR3, {24'h0, p[71:64]});
      bus(1'b1, ADR_IRQMK, 32'h2);
      chk(irq, 1);
      bus(1'b1, ADR_IRQST, 32'h2);
      chk(irq, 0);
      bus(1'b1, ADR_CMD, 32'h3);
      rd(ADR_CMD, 32'h1);
      foreach (outcomes[i]) begin
         pulse(outcomes[i]);
         rd(ADR_STAT, {30'h0, outcomes[i]});
      end
      rd(ADR_IRQST, 32'h1);
      // A read-done pulse while the clock enable is low must leave the outcome alone
      ce <= 1'b0;
      pulse(2'h2);
      ce <= 1'b1;
      rd(ADR_STAT, 32'h1);
      bus(1'b1, ADR_CMD, 32'h3);
      rd(ADR_CMD, 32'h3);
      waitIrq(IRQ_RELOAD);
      rd(ADR_CMD, 32'h1);
      chk(inCount, BLK);
      chk(inBad, 0);
      conclude;
   end
endmodule
